// *** abx_cfg.svh ***
// Constants for the arithmetic, logic, multiply and branch execution unit.
// Assumes it is included by the execution module only.
`ifndef ABX_CFG_SVH
`define ABX_CFG_SVH
`define ABX_OFF_CTRL 8'h00
`define ABX_OFF_OPA 8'h04
`define ABX_OFF_OPB 8'h08
`define ABX_OFF_KOFF 8'h0C
`define ABX_OFF_ZPTR 8'h10
`define ABX_OFF_PC 8'h14
`define ABX_OFF_FLAGS 8'h18
`define ABX_OFF_RESULT 8'h1C
`define ABX_OFF_STATUS 8'h20
`define ABX_OFF_IOADDR 8'h24
`define ABX_CTRL_OP 5:0
`define ABX_CTRL_SEL 8:6
`define ABX_CTRL_TWO 9
`define ABX_REL_K 11:0
`define ABX_F_C 0
`define ABX_F_Z 1
`define ABX_F_N 2
`define ABX_F_V 3
`define ABX_F_S 4
`define ABX_F_H 5
`define ABX_F_I 7
`define ABX_FLAGS_RST 8'h00
`define ABX_PC_RST 16'h0000
`define ABX_PC_STEP 16'h0001
`define ABX_PC_SKIP1 16'h0002
`define ABX_PC_SKIP2 16'h0003
`define ABX_BYTE_ALL 8'hFF
`define ABX_BIT_ONE 8'h01
`define ABX_IO_BIT_MAX 6'h1F
`define ABX_CYC_1 3'h1
`define ABX_CYC_2 3'h2
`define ABX_CYC_3 3'h3
`define ABX_CYC_4 3'h4
`endif

// *** abx_pkg.sv ***
// Types shared by the execution unit and its testbench.
// Assumes the constants header is on the include path.
package abx_pkg;
  typedef enum logic [5:0] {
    OP_SUM = 6'b000000, OP_SUM_CARRY = 6'b000001, OP_DIFFERENCE = 6'b000010,
    OP_DIFFERENCE_WITH_BORROW = 6'b000011, OP_PAIR_PLUS_IMMEDIATE = 6'b000100,
    OP_PAIR_MINUS_IMMEDIATE = 6'b000101, OP_CONJUNCTION = 6'b000110,
    OP_DISJUNCTION = 6'b000111, OP_EXCLUSIVE_DISJUNCTION = 6'b001000,
    OP_CLEAR_MASK_BITS = 6'b001001, OP_MASK_BITS_SET = 6'b001010,
    OP_ZERO_SIGN_TEST = 6'b001011, OP_PRODUCT_UNSIGNED = 6'b001100,
    OP_PRODUCT_SIGNED = 6'b001101, OP_PRODUCT_MIXED_SIGN = 6'b001110,
    OP_FRACTION_PRODUCT_UNSIGNED = 6'b001111, OP_FRACTION_PRODUCT_SIGNED = 6'b010000,
    OP_FRACTION_PRODUCT_MIXED = 6'b010001, OP_RELATIVE_JUMP = 6'b010010,
    OP_INDIRECT_JUMP = 6'b010011, OP_DIRECT_JUMP = 6'b010100,
    OP_RELATIVE_INVOKE = 6'b010101, OP_INDIRECT_INVOKE = 6'b010110,
    OP_DIRECT_INVOKE = 6'b010111, OP_SUBROUTINE_EXIT = 6'b011000,
    OP_INTERRUPT_EXIT = 6'b011001, OP_EQUAL_SKIP = 6'b011010,
    OP_COMPARE_REGISTERS = 6'b011011, OP_COMPARE_WITH_BORROW = 6'b011100,
    OP_SKIP_REG_BIT_CLEAR = 6'b011101, OP_SKIP_REG_BIT_SET = 6'b011110,
    OP_SKIP_IO_BIT_CLEAR = 6'b011111, OP_SKIP_IO_BIT_SET = 6'b100000,
    OP_BRANCH_FLAG_SET = 6'b100001, OP_BRANCH_FLAG_CLEAR = 6'b100010,
    OP_BRANCH_SIGNED_GE = 6'b100011, OP_BRANCH_SIGNED_LT = 6'b100100,
    OP_BRANCH_UNSIGNED_HIGHER_SAME = 6'b100101, OP_BRANCH_UNSIGNED_LOWER = 6'b100110,
    OP_IO_BIT_SET = 6'b100111, OP_IO_BIT_CLEAR = 6'b101000
  } abx_op_e;

  typedef struct packed {
    logic [15:0] value;
    logic [7:0] flags;
    logic wr;
  } abx_alu_s;

  typedef struct packed {
    logic [15:0] pc;
    logic [2:0] cycles;
    logic push;
    logic pop;
    logic set_ie;
  } abx_flow_s;

  typedef struct packed {
    logic en;
    logic [5:0] addr;
    logic [7:0] data;
  } abx_io_s;
endpackage

// *** abx_exec.sv ***
// Execution unit for arithmetic, logic, multiply, jump, invoke, skip and branch
// operations, driven by software over an Avalon-MM slave with waitrequest.
// Assumes io_rd_data is combinational I/O space data on the same clock for io_addr.
`timescale 1ns/1ps
`include "abx_cfg.svh"

module abx_exec #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [5:0] io_addr,
  input wire logic [7:0] io_rd_data,
  output abx_pkg::abx_io_s io_wr
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  logic [7:0] opa_lo_reg;
  logic [7:0] opa_hi_reg;
  logic [7:0] opb_reg;
  logic [15:0] koff_reg;
  logic [15:0] z_reg;
  logic [15:0] pc_reg;
  logic [7:0] flag_reg;
  logic [15:0] result_reg;
  logic result_wr_reg;
  logic [2:0] busy_reg;
  logic [2:0] last_cycles_reg;
  logic io_err_reg;
  logic [15:0] stack_mem [STACK_DEPTH];
  logic [SP_W-1:0] sp_reg;
  logic [31:0] rd_next;
  logic wr_fire;
  logic start;
  abx_pkg::abx_op_e op;
  logic [2:0] sel;
  logic two_word;
  logic io_ok;
  abx_pkg::abx_alu_s alu;
  abx_pkg::abx_flow_s flow;
  abx_pkg::abx_io_s io_next;

  // ==========================================================================
  // Datapath helpers
  function automatic abx_pkg::abx_alu_s arith8(input logic [7:0] a, input logic [7:0] b,
                                               input logic cin, input logic sub,
                                               input logic [7:0] f);
    abx_pkg::abx_alu_s o;
    logic [8:0] r;
    logic [4:0] h;
    o = '0;
    o.flags = f;
    if (sub) begin
      r = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      o.flags[`ABX_F_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    end else begin
      r = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      o.flags[`ABX_F_V] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
    end
    o.value = {8'h00, r[7:0]};
    o.wr = 1'b1;
    o.flags[`ABX_F_C] = r[8];
    o.flags[`ABX_F_H] = h[4];
    o.flags[`ABX_F_Z] = (r[7:0] == 8'h00);
    o.flags[`ABX_F_N] = r[7];
    return o;
  endfunction

  function automatic abx_pkg::abx_alu_s logic8(input logic [7:0] r, input logic [7:0] f);
    abx_pkg::abx_alu_s o;
    o = '0;
    o.flags = f;
    o.value = {8'h00, r};
    o.wr = 1'b1;
    o.flags[`ABX_F_Z] = (r == 8'h00);
    o.flags[`ABX_F_N] = r[7];
    o.flags[`ABX_F_V] = 1'b0;
    return o;
  endfunction

  function automatic abx_pkg::abx_alu_s word16(input logic [15:0] a, input logic [7:0] k,
                                               input logic sub, input logic [7:0] f);
    abx_pkg::abx_alu_s o;
    logic [16:0] r;
    o = '0;
    o.flags = f;
    r = sub ? ({1'b0, a} - {9'h000, k}) : ({1'b0, a} + {9'h000, k});
    o.value = r[15:0];
    o.wr = 1'b1;
    o.flags[`ABX_F_C] = r[16];
    o.flags[`ABX_F_Z] = (r[15:0] == 16'h0000);
    o.flags[`ABX_F_N] = r[15];
    o.flags[`ABX_F_V] = sub ? (a[15] & ~r[15]) : (~a[15] & r[15]);
    o.flags[`ABX_F_S] = r[15] ^ o.flags[`ABX_F_V];
    return o;
  endfunction

  function automatic abx_pkg::abx_alu_s prod(input logic [7:0] a, input logic [7:0] b,
                                             input logic sa, input logic sb,
                                             input logic frac, input logic [7:0] f);
    abx_pkg::abx_alu_s o;
    logic signed [8:0] ea;
    logic signed [8:0] eb;
    logic signed [17:0] p;
    o = '0;
    o.flags = f;
    ea = $signed({sa & a[7], a});
    eb = $signed({sb & b[7], b});
    p = ea * eb;
    o.value = frac ? {p[14:0], 1'b0} : p[15:0];
    o.wr = 1'b1;
    o.flags[`ABX_F_C] = p[15];
    o.flags[`ABX_F_Z] = (o.value == 16'h0000);
    return o;
  endfunction

  // ==========================================================================
  // Operation decode
  assign wr_fire = avs_write & ~avs_waitrequest;
  assign start = wr_fire & (avs_address == `ABX_OFF_CTRL);
  assign op = abx_pkg::abx_op_e'(avs_writedata[`ABX_CTRL_OP]);
  assign sel = avs_writedata[`ABX_CTRL_SEL];
  assign two_word = avs_writedata[`ABX_CTRL_TWO];
  assign io_ok = (io_addr <= `ABX_IO_BIT_MAX);

  always_comb begin
    alu = '0;
    alu.flags = flag_reg;
    unique case (op)
      abx_pkg::OP_SUM: alu = arith8(opa_lo_reg, opb_reg, 1'b0, 1'b0, flag_reg);
      abx_pkg::OP_SUM_CARRY:
        alu = arith8(opa_lo_reg, opb_reg, flag_reg[`ABX_F_C], 1'b0, flag_reg);
      abx_pkg::OP_DIFFERENCE:
        alu = arith8(opa_lo_reg, opb_reg, 1'b0, 1'b1, flag_reg);
      abx_pkg::OP_DIFFERENCE_WITH_BORROW:
        alu = arith8(opa_lo_reg, opb_reg, flag_reg[`ABX_F_C], 1'b1, flag_reg);
      abx_pkg::OP_PAIR_PLUS_IMMEDIATE:
        alu = word16({opa_hi_reg, opa_lo_reg}, opb_reg, 1'b0, flag_reg);
      abx_pkg::OP_PAIR_MINUS_IMMEDIATE:
        alu = word16({opa_hi_reg, opa_lo_reg}, opb_reg, 1'b1, flag_reg);
      abx_pkg::OP_CONJUNCTION: alu = logic8(opa_lo_reg & opb_reg, flag_reg);
      abx_pkg::OP_DISJUNCTION: alu = logic8(opa_lo_reg | opb_reg, flag_reg);
      abx_pkg::OP_EXCLUSIVE_DISJUNCTION: alu = logic8(opa_lo_reg ^ opb_reg, flag_reg);
      abx_pkg::OP_CLEAR_MASK_BITS:
        alu = logic8(opa_lo_reg & (`ABX_BYTE_ALL - opb_reg), flag_reg);
      abx_pkg::OP_MASK_BITS_SET: alu = logic8(opa_lo_reg | opb_reg, flag_reg);
      abx_pkg::OP_ZERO_SIGN_TEST: begin
        alu = logic8(opa_lo_reg & opa_lo_reg, flag_reg);
        alu.wr = 1'b0;
      end
      abx_pkg::OP_PRODUCT_UNSIGNED:
        alu = prod(opa_lo_reg, opb_reg, 1'b0, 1'b0, 1'b0, flag_reg);
      abx_pkg::OP_PRODUCT_SIGNED:
        alu = prod(opa_lo_reg, opb_reg, 1'b1, 1'b1, 1'b0, flag_reg);
      abx_pkg::OP_PRODUCT_MIXED_SIGN:
        alu = prod(opa_lo_reg, opb_reg, 1'b1, 1'b0, 1'b0, flag_reg);
      abx_pkg::OP_FRACTION_PRODUCT_UNSIGNED:
        alu = prod(opa_lo_reg, opb_reg, 1'b0, 1'b0, 1'b1, flag_reg);
      abx_pkg::OP_FRACTION_PRODUCT_SIGNED:
        alu = prod(opa_lo_reg, opb_reg, 1'b1, 1'b1, 1'b1, flag_reg);
      abx_pkg::OP_FRACTION_PRODUCT_MIXED:
        alu = prod(opa_lo_reg, opb_reg, 1'b1, 1'b0, 1'b1, flag_reg);
      abx_pkg::OP_COMPARE_REGISTERS: begin
        alu = arith8(opa_lo_reg, opb_reg, 1'b0, 1'b1, flag_reg);
        alu.wr = 1'b0;
      end
      abx_pkg::OP_COMPARE_WITH_BORROW: begin
        alu = arith8(opa_lo_reg, opb_reg, flag_reg[`ABX_F_C], 1'b1, flag_reg);
        alu.wr = 1'b0;
      end
      default: alu.wr = 1'b0;
    endcase
  end

  // ==========================================================================
  // Program flow: next PC, cycle count and stack action
  logic [15:0] pc_seq;
  logic [15:0] pc_rel;
  logic [15:0] pc_skip;
  logic skip_hit;
  logic branch_hit;

  assign pc_seq = pc_reg + `ABX_PC_STEP;
  assign pc_rel = pc_reg + 16'($signed(koff_reg[`ABX_REL_K])) + `ABX_PC_STEP;
  assign pc_skip = pc_reg + (two_word ? `ABX_PC_SKIP2 : `ABX_PC_SKIP1);

  always_comb begin
    skip_hit = 1'b0;
    branch_hit = 1'b0;
    unique case (op)
      abx_pkg::OP_EQUAL_SKIP: skip_hit = (opa_lo_reg == opb_reg);
      abx_pkg::OP_SKIP_REG_BIT_CLEAR: skip_hit = ~opb_reg[sel];
      abx_pkg::OP_SKIP_REG_BIT_SET: skip_hit = opb_reg[sel];
      abx_pkg::OP_SKIP_IO_BIT_CLEAR: skip_hit = io_ok & ~io_rd_data[sel];
      abx_pkg::OP_SKIP_IO_BIT_SET: skip_hit = io_ok & io_rd_data[sel];
      abx_pkg::OP_BRANCH_FLAG_SET: branch_hit = flag_reg[sel];
      abx_pkg::OP_BRANCH_FLAG_CLEAR: branch_hit = ~flag_reg[sel];
      abx_pkg::OP_BRANCH_SIGNED_GE:
        branch_hit = ~(flag_reg[`ABX_F_N] ^ flag_reg[`ABX_F_V]);
      abx_pkg::OP_BRANCH_SIGNED_LT:
        branch_hit = flag_reg[`ABX_F_N] ^ flag_reg[`ABX_F_V];
      abx_pkg::OP_BRANCH_UNSIGNED_HIGHER_SAME: branch_hit = ~flag_reg[`ABX_F_C];
      abx_pkg::OP_BRANCH_UNSIGNED_LOWER: branch_hit = flag_reg[`ABX_F_C];
      default: skip_hit = 1'b0;
    endcase
  end

  always_comb begin
    flow = '0;
    flow.pc = pc_seq;
    flow.cycles = `ABX_CYC_1;
    unique case (op)
      abx_pkg::OP_PAIR_PLUS_IMMEDIATE, abx_pkg::OP_PAIR_MINUS_IMMEDIATE,
      abx_pkg::OP_PRODUCT_UNSIGNED, abx_pkg::OP_PRODUCT_SIGNED, abx_pkg::OP_PRODUCT_MIXED_SIGN,
      abx_pkg::OP_FRACTION_PRODUCT_UNSIGNED, abx_pkg::OP_FRACTION_PRODUCT_SIGNED,
      abx_pkg::OP_FRACTION_PRODUCT_MIXED: flow.cycles = `ABX_CYC_2;
      abx_pkg::OP_RELATIVE_JUMP: begin
        flow.pc = pc_rel;
        flow.cycles = `ABX_CYC_2;
      end
      abx_pkg::OP_INDIRECT_JUMP: begin
        flow.pc = z_reg;
        flow.cycles = `ABX_CYC_2;
      end
      abx_pkg::OP_DIRECT_JUMP: begin
        flow.pc = koff_reg;
        flow.cycles = `ABX_CYC_3;
      end
      abx_pkg::OP_RELATIVE_INVOKE: begin
        flow.pc = pc_rel;
        flow.cycles = `ABX_CYC_3;
        flow.push = 1'b1;
      end
      abx_pkg::OP_INDIRECT_INVOKE: begin
        flow.pc = z_reg;
        flow.cycles = `ABX_CYC_3;
        flow.push = 1'b1;
      end
      abx_pkg::OP_DIRECT_INVOKE: begin
        flow.pc = koff_reg;
        flow.cycles = `ABX_CYC_4;
        flow.push = 1'b1;
      end
      abx_pkg::OP_SUBROUTINE_EXIT, abx_pkg::OP_INTERRUPT_EXIT: begin
        flow.pc = stack_mem[sp_reg - SP_W'(1)];
        flow.cycles = `ABX_CYC_4;
        flow.pop = 1'b1;
        flow.set_ie = (op == abx_pkg::OP_INTERRUPT_EXIT);
      end
      abx_pkg::OP_EQUAL_SKIP, abx_pkg::OP_SKIP_REG_BIT_CLEAR, abx_pkg::OP_SKIP_REG_BIT_SET,
      abx_pkg::OP_SKIP_IO_BIT_CLEAR, abx_pkg::OP_SKIP_IO_BIT_SET: begin
        if (skip_hit) begin
          flow.pc = pc_skip;
          flow.cycles = two_word ? `ABX_CYC_3 : `ABX_CYC_2;
        end
      end
      abx_pkg::OP_BRANCH_FLAG_SET, abx_pkg::OP_BRANCH_FLAG_CLEAR,
      abx_pkg::OP_BRANCH_SIGNED_GE, abx_pkg::OP_BRANCH_SIGNED_LT,
      abx_pkg::OP_BRANCH_UNSIGNED_HIGHER_SAME, abx_pkg::OP_BRANCH_UNSIGNED_LOWER: begin
        if (branch_hit) begin
          flow.pc = pc_rel;
          flow.cycles = `ABX_CYC_2;
        end
      end
      default: flow.cycles = `ABX_CYC_1;
    endcase
  end

  // Single-bit I/O writes return the whole byte as read, so set flags of the
  // write-one-to-clear kind are written back as one and get cleared.
  always_comb begin
    io_next = '0;
    io_next.addr = io_addr;
    if (op == abx_pkg::OP_IO_BIT_SET) begin
      io_next.en = io_ok;
      io_next.data = io_rd_data | (`ABX_BIT_ONE << sel);
    end else if (op == abx_pkg::OP_IO_BIT_CLEAR) begin
      io_next.en = io_ok;
      io_next.data = io_rd_data & ~(`ABX_BIT_ONE << sel);
    end
  end

  // ==========================================================================
  // Architectural state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_reg <= `ABX_PC_RST;
    end else if (start) begin
      pc_reg <= flow.pc;
    end else if (wr_fire && avs_address == `ABX_OFF_PC) begin
      pc_reg <= avs_writedata[15:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= `ABX_FLAGS_RST;
    end else if (start) begin
      flag_reg <= alu.flags;
      if (flow.set_ie) begin
        flag_reg[`ABX_F_I] <= 1'b1;
      end
    end else if (wr_fire && avs_address == `ABX_OFF_FLAGS) begin
      flag_reg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_reg <= 16'h0000;
      result_wr_reg <= 1'b0;
    end else if (start) begin
      result_wr_reg <= alu.wr;
      if (alu.wr) begin
        result_reg <= alu.value;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opa_lo_reg <= 8'h00;
      opa_hi_reg <= 8'h00;
      opb_reg <= 8'h00;
      koff_reg <= 16'h0000;
      z_reg <= 16'h0000;
      io_addr <= 6'h00;
    end else if (wr_fire) begin
      unique case (avs_address)
        `ABX_OFF_OPA: {opa_hi_reg, opa_lo_reg} <= avs_writedata[15:0];
        `ABX_OFF_OPB: opb_reg <= avs_writedata[7:0];
        `ABX_OFF_KOFF: koff_reg <= avs_writedata[15:0];
        `ABX_OFF_ZPTR: z_reg <= avs_writedata[15:0];
        `ABX_OFF_IOADDR: io_addr <= avs_writedata[5:0];
        default: io_addr <= io_addr;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (start && flow.push) begin
      stack_mem[sp_reg] <= (op == abx_pkg::OP_DIRECT_INVOKE) ? pc_reg + `ABX_PC_SKIP1 : pc_seq;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sp_reg <= '0;
    end else if (start && flow.push) begin
      sp_reg <= sp_reg + SP_W'(1);
    end else if (start && flow.pop) begin
      sp_reg <= sp_reg - SP_W'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io_wr <= '0;
      io_err_reg <= 1'b0;
    end else begin
      io_wr <= start ? io_next : '0;
      if (start) begin
        io_err_reg <= ~io_ok & (op == abx_pkg::OP_IO_BIT_SET || op == abx_pkg::OP_IO_BIT_CLEAR ||
                                op == abx_pkg::OP_SKIP_IO_BIT_CLEAR ||
                                op == abx_pkg::OP_SKIP_IO_BIT_SET);
      end
    end
  end

  // Busy holds off the bus for the remaining cycles of a multi-cycle operation.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 3'h0;
      last_cycles_reg <= 3'h0;
    end else if (start) begin
      busy_reg <= flow.cycles - `ABX_CYC_1;
      last_cycles_reg <= flow.cycles;
    end else if (busy_reg != 3'h0) begin
      busy_reg <= busy_reg - 3'h1;
    end
  end

  // ==========================================================================
  // Avalon-MM slave
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (avs_address)
      `ABX_OFF_OPA: rd_next = {16'h0000, opa_hi_reg, opa_lo_reg};
      `ABX_OFF_OPB: rd_next = {24'h00_0000, opb_reg};
      `ABX_OFF_KOFF: rd_next = {16'h0000, koff_reg};
      `ABX_OFF_ZPTR: rd_next = {16'h0000, z_reg};
      `ABX_OFF_PC: rd_next = {16'h0000, pc_reg};
      `ABX_OFF_FLAGS: rd_next = {24'h00_0000, flag_reg};
      `ABX_OFF_RESULT: rd_next = {15'h0000, result_wr_reg, result_reg};
      `ABX_OFF_STATUS: rd_next = {20'h0_0000, 1'b0, last_cycles_reg, 3'h0, io_err_reg,
                                  4'h0};
      `ABX_OFF_IOADDR: rd_next = {26'h000_0000, io_addr};
      default: rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && busy_reg == 3'h0) begin
      avs_waitrequest <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest && busy_reg == 3'h0) begin
      avs_readdata <= rd_next;
    end
  end
endmodule

// *** abx_monitor.sv ***
// Checker for the execution unit's bus handshake and I/O write port.
// Assumes it is bound to abx_exec and sees only its ports.
`timescale 1ns/1ps
module abx_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_rd_data,
  input abx_pkg::abx_io_s io_wr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // Handshake and I/O write checks
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("accept longer than one cycle");
  a_accept_bounded: assert property ((avs_read || avs_write) && avs_waitrequest
    |-> ##[1:8] !avs_waitrequest) else $error("request never accepted");
  a_ctrl_reads_zero: assert property (!avs_waitrequest && avs_read && avs_address == 8'h00
    |-> avs_readdata == 32'h0000_0000) else $error("control read not zero");
  a_long_stall: assert property (
    !avs_waitrequest && avs_write && avs_address == 8'h00 && avs_writedata[5:0] == 6'h17
    |=> avs_waitrequest [*3]) else $error("four cycle op not stalled");
  a_io_from_ctrl: assert property (io_wr.en
    |-> $past(!avs_waitrequest && avs_write && avs_address == 8'h00))
    else $error("io write without control write");
  a_io_in_range: assert property (io_wr.en |-> io_wr.addr <= 6'h1F)
    else $error("io write above range");
  a_io_pulse_once: assert property (io_wr.en |=> !io_wr.en)
    else $error("io write pulse too long");
  a_io_same_addr: assert property (io_wr.en |-> io_wr.addr == io_addr)
    else $error("io write address wrong");
  a_io_set_merge: assert property (io_wr.en && $past(avs_writedata[5:0]) == 6'h27
    |-> io_wr.data == ($past(io_rd_data) | (8'h01 << $past(avs_writedata[8:6]))))
    else $error("bit set data wrong");
  a_io_clr_merge: assert property (io_wr.en && $past(avs_writedata[5:0]) == 6'h28
    |-> io_wr.data == ($past(io_rd_data) & ~(8'h01 << $past(avs_writedata[8:6]))))
    else $error("bit clear data wrong");
endmodule

// *** abx_io_model.sv ***
// I/O space stand-in: 64 byte registers read at once, written by io_wr.
// Assumes io_wr.en is a one-cycle pulse on the core clock.
`timescale 1ns/1ps
module abx_io_model (
  input wire logic clk,
  input wire logic [5:0] io_addr,
  output logic [7:0] io_rd_data,
  input abx_pkg::abx_io_s io_wr
);
  logic [7:0] mem [64];
  initial begin
    foreach (mem[i]) begin
      mem[i] = 8'h10;
    end
  end
  assign io_rd_data = mem[io_addr];
  always @(posedge clk) begin
    if (io_wr.en) begin
      mem[io_wr.addr] <= io_wr.data;
    end
  end
endmodule

// *** abx_exec_tb.sv ***
// Testbench for abx_exec over its Avalon-MM slave.
// Assumes abx_io_model stands in for the I/O space.
`timescale 1ns/1ps
module abx_exec_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [5:0] io_addr;
  logic [7:0] io_rd_data;
  abx_pkg::abx_io_s io_wr;
  logic [31:0] q;
  int error_cnt = 0;
  int checked = 0;
  always #4 clk = ~clk;
  abx_exec i_dut (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .io_addr(io_addr), .io_rd_data(io_rd_data), .io_wr(io_wr));
  abx_io_model i_io (.clk(clk), .io_addr(io_addr), .io_rd_data(io_rd_data), .io_wr(io_wr));
  // ==========================================================
  // Bus access and comparison
  task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 99) begin
      @(posedge clk);
      n++;
    end
    if (n == 99) error_cnt++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic results();
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Sets flags, starts the op, then checks masked flags and cycle count.
  task automatic run(input logic [9:0] c, input logic [7:0] f, input logic [7:0] x,
      input logic [7:0] m, input logic [2:0] y);
    acc(8'h18, 1'b1, {24'h00_0000, f});
    acc(8'h00, 1'b1, {22'h00_0000, c});
    acc(8'h18, 1'b0, 32'h0000_0000);
    chk(q & {24'h00_0000, m}, {24'h00_0000, x});
    acc(8'h20, 1'b0, 32'h0000_0000);
    chk({29'h0000_0000, q[10:8]}, {29'h0000_0000, y});
  endtask
  task automatic alu(input logic [9:0] c, input logic [15:0] a, input logic [7:0] b,
      input logic [7:0] f, input logic [16:0] r, input logic [7:0] x, input logic [7:0] m,
      input logic [2:0] y);
    acc(8'h04, 1'b1, {16'h0000, a});
    acc(8'h08, 1'b1, {24'h00_0000, b});
    run(c, f, x, m, y);
    acc(8'h1C, 1'b0, 32'h0000_0000);
    chk(q & 32'h0001_FFFF, {15'h0000, r});
  endtask
  task automatic flw(input logic [9:0] c, input logic [7:0] f, input logic [15:0] p,
      input logic [2:0] y, input logic [7:0] x);
    acc(8'h14, 1'b1, 32'h0000_0100);
    run(c, f, x, 8'hFF, y);
    acc(8'h14, 1'b0, 32'h0000_0000);
    chk(q & 32'h0000_FFFF, {16'h0000, p});
  endtask
  // ==========================================================
  // Test sequence
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    acc(8'h40, 1'b1, 32'hFFFF_FFFF);
    acc(8'h40, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    alu(10'h000, 16'h000F, 8'h01, 8'h00, 17'h1_0010, 8'h20, 8'h2F, 3'h1);
    alu(10'h001, 16'h00FF, 8'h00, 8'h01, 17'h1_0000, 8'h23, 8'h2F, 3'h1);
    alu(10'h002, 16'h0000, 8'h01, 8'h00, 17'h1_00FF, 8'h25, 8'h2F, 3'h1);
    alu(10'h003, 16'h0080, 8'h00, 8'h01, 17'h1_007F, 8'h28, 8'h2F, 3'h1);
    alu(10'h004, 16'hFFFF, 8'h01, 8'h00, 17'h1_0000, 8'h03, 8'h1F, 3'h2);
    alu(10'h005, 16'h0000, 8'h01, 8'h00, 17'h1_FFFF, 8'h15, 8'h1F, 3'h2);
    alu(10'h006, 16'h00F0, 8'h3C, 8'h08, 17'h1_0030, 8'h00, 8'h0E, 3'h1);
    alu(10'h007, 16'h0080, 8'h01, 8'h00, 17'h1_0081, 8'h04, 8'h0E, 3'h1);
    alu(10'h008, 16'h005A, 8'h5A, 8'h00, 17'h1_0000, 8'h02, 8'h0E, 3'h1);
    alu(10'h009, 16'h00FF, 8'h0F, 8'h00, 17'h1_00F0, 8'h04, 8'h0E, 3'h1);
    alu(10'h00A, 16'h0000, 8'h00, 8'h00, 17'h1_0000, 8'h02, 8'h0E, 3'h1);
    alu(10'h00B, 16'h0080, 8'h00, 8'h00, 17'h0_0000, 8'h04, 8'h0E, 3'h1);
    alu(10'h00C, 16'h00FF, 8'hFF, 8'h00, 17'h1_FE01, 8'h01, 8'h03, 3'h2);
    alu(10'h00D, 16'h00FF, 8'h02, 8'h00, 17'h1_FFFE, 8'h01, 8'h03, 3'h2);
    alu(10'h00E, 16'h00FF, 8'h02, 8'h00, 17'h1_FFFE, 8'h01, 8'h03, 3'h2);
    alu(10'h00F, 16'h0080, 8'h80, 8'h00, 17'h1_8000, 8'h00, 8'h03, 3'h2);
    alu(10'h010, 16'h0040, 8'h40, 8'h00, 17'h1_2000, 8'h00, 8'h03, 3'h2);
    alu(10'h011, 16'h0000, 8'h55, 8'h00, 17'h1_0000, 8'h02, 8'h03, 3'h2);
    alu(10'h01B, 16'h0001, 8'h02, 8'h00, 17'h0_0000, 8'h25, 8'h2F, 3'h1);
    alu(10'h01C, 16'h0005, 8'h05, 8'h01, 17'h0_0000, 8'h25, 8'h2F, 3'h1);
    acc(8'h04, 1'b1, 32'h0000_00F7);
    acc(8'h08, 1'b1, 32'h0000_00F7);
    acc(8'h0C, 1'b1, 32'h0000_0005);
    acc(8'h10, 1'b1, 32'h0000_1234);
    acc(8'h24, 1'b1, 32'h0000_0005);
    flw(10'h012, 8'h00, 16'h0106, 3'h2, 8'h00);
    flw(10'h013, 8'h00, 16'h1234, 3'h2, 8'h00);
    flw(10'h014, 8'h00, 16'h0005, 3'h3, 8'h00);
    flw(10'h015, 8'h00, 16'h0106, 3'h3, 8'h00);
    flw(10'h018, 8'h00, 16'h0101, 3'h4, 8'h00);
    flw(10'h017, 8'h00, 16'h0005, 3'h4, 8'h00);
    flw(10'h019, 8'h00, 16'h0102, 3'h4, 8'h80);
    flw(10'h016, 8'h00, 16'h1234, 3'h3, 8'h00);
    flw(10'h01A, 8'h00, 16'h0102, 3'h2, 8'h00);
    flw(10'h21A, 8'h00, 16'h0103, 3'h3, 8'h00);
    flw(10'h0DD, 8'h00, 16'h0102, 3'h2, 8'h00);
    flw(10'h0DE, 8'h00, 16'h0101, 3'h1, 8'h00);
    flw(10'h320, 8'h00, 16'h0103, 3'h3, 8'h00);
    flw(10'h11F, 8'h00, 16'h0101, 3'h1, 8'h00);
    flw(10'h061, 8'h02, 16'h0106, 3'h2, 8'h02);
    flw(10'h062, 8'h02, 16'h0101, 3'h1, 8'h02);
    flw(10'h023, 8'h0C, 16'h0106, 3'h2, 8'h0C);
    flw(10'h024, 8'h0C, 16'h0101, 3'h1, 8'h0C);
    flw(10'h024, 8'h04, 16'h0106, 3'h2, 8'h04);
    flw(10'h025, 8'h01, 16'h0101, 3'h1, 8'h01);
    flw(10'h026, 8'h01, 16'h0106, 3'h2, 8'h01);
    acc(8'h00, 1'b1, 32'h0000_0027);
    acc(8'h20, 1'b0, 32'h0000_0000);
    chk({24'h00_0000, i_io.mem[5]}, 32'h0000_0011);
    acc(8'h00, 1'b1, 32'h0000_0128);
    acc(8'h20, 1'b0, 32'h0000_0000);
    chk({24'h00_0000, i_io.mem[5]}, 32'h0000_0001);
    acc(8'h24, 1'b1, 32'h0000_0020);
    acc(8'h00, 1'b1, 32'h0000_0027);
    acc(8'h20, 1'b0, 32'h0000_0000);
    chk(q & 32'h0000_0010, 32'h0000_0010);
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end
endmodule
bind abx_exec abx_monitor i_mon (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .io_addr(io_addr), .io_rd_data(io_rd_data), .io_wr(io_wr));
